// File: rtl/dvi_info_bank.sv
// Purpose: APB register bank of device information and scratch values
// Assumes: APB master keeps the request steady until pready
// Notes:   Every access answers in the second access cycle
`timescale 1ns/1ps
// Behaviour
// [RULE1] Maker, product, maker extra, hardware and firmware revisions are read only.
// [RULE2] The user assigned label is writable and reads back as written.
// [RULE3] The capture geometry register is read only and always reports area scan.
// [RULE4] Imager columns and imager rows are reported in separate read only registers.
// [RULE5] Read only limits report the largest accepted ROI width and height.
// [RULE6] A read only identifier reports the unit serial code.
// [RULE7] Five signed 32-bit scratch values are written and read back unchanged.
// [RULE8] Scratch values influence nothing else in the device.
// [RULE9] The slot picker routes scratch data reads and writes to one value.
// [RULE10] Each scratch value also has its own directly addressed register.
// [RULE11] Writes to read only registers are dropped without any side effect.
module dvi_info_bank #(
   parameter logic [31:0] MAKER_WORD = 32'h4d4b_0001,    // Arbitrary value
   parameter logic [31:0] PRODUCT_WORD = 32'h5044_0002,  // Arbitrary value
   parameter logic [31:0] EXTRA_WORD = 32'h6e6f_6e65,    // Arbitrary value
   parameter logic [31:0] HW_REV_WORD = 32'h0000_0100,   // Arbitrary value
   parameter logic [31:0] FW_REV_WORD = 32'h0000_0200,   // Arbitrary value
   parameter logic [31:0] SERIAL_WORD = 32'h0012_3456,   // Arbitrary value
   parameter logic [31:0] IMAGER_COLS = 32'h0000_0800,
   parameter logic [31:0] IMAGER_ROWS = 32'h0000_0440,
   parameter logic [31:0] ROI_COL_LIMIT = 32'h0000_0800,
   parameter logic [31:0] ROI_ROW_LIMIT = 32'h0000_0440
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);

   // ======================================================
   // Elaboration checks
   if (IMAGER_COLS == 32'h0000_0000 || IMAGER_ROWS == 32'h0000_0000) begin : g_chk_dim
      $error("dvi_info_bank: imager size must be non zero");
   end
   if (ROI_COL_LIMIT > IMAGER_COLS || ROI_ROW_LIMIT > IMAGER_ROWS) begin : g_chk_roi
      $error("dvi_info_bank: ROI limits exceed imager size");
   end

   // ======================================================
   // Reset release through two flip-flops
   logic rst_meta_reg;
   logic rst_sync_reg;

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ======================================================
   // Address decode helpers
   function automatic logic is_slot_addr(input logic [7:0] a);
      return (a[7:2] >= dvi_pkg::OFS_SLOT1[7:2]) && (a[7:2] <= dvi_pkg::OFS_SLOT5[7:2]);
   endfunction

   function automatic logic [2:0] slot_of_addr(input logic [7:0] a);
      logic [5:0] d;
      d = a[7:2] - dvi_pkg::OFS_SLOT1[7:2];
      return d[2:0];
   endfunction

   function automatic logic is_label_addr(input logic [7:0] a);
      return (a[7:2] >= dvi_pkg::OFS_LABEL[7:2]) && (a[7:2] <= dvi_pkg::OFS_LABEL_LAST[7:2]);
   endfunction

   function automatic logic [1:0] label_of_addr(input logic [7:0] a);
      logic [5:0] d;
      d = a[7:2] - dvi_pkg::OFS_LABEL[7:2];
      return d[1:0];
   endfunction

   function automatic logic is_word(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction

   // ======================================================
   // APB phase tracking
   dvi_pkg::dvi_apb_req_s req;
   logic access;
   logic commit;
   logic wr_commit;

   // Request fields travel together
   assign req.addr = i_paddr;
   assign req.write = i_pwrite;
   assign req.wdata = i_pwdata;
   // First access cycle prepares the answer, second one commits it
   assign access = i_psel && i_penable && !o_pready;
   assign commit = i_psel && i_penable && o_pready;
   assign wr_commit = commit && req.write;

   // ======================================================
   // Writable state
   logic [31:0] label_reg [dvi_pkg::LABEL_WORDS];
   dvi_pkg::dvi_slot_e pick_reg;
   logic signed [31:0] slots [dvi_pkg::SLOTS];
   dvi_pkg::dvi_slot_wr_s slot_wr;

   // Decode of the held address
   logic hit_label;
   logic hit_pick;
   logic hit_data;
   logic hit_slot;
   logic hit_ro;
   logic pick_legal;
   logic mapped;

   assign hit_label = is_label_addr(req.addr);
   assign hit_pick = is_word(req.addr, dvi_pkg::OFS_PICK);
   assign hit_data = is_word(req.addr, dvi_pkg::OFS_SLOT_DATA);
   assign hit_slot = is_slot_addr(req.addr);
   assign hit_ro = is_word(req.addr, dvi_pkg::OFS_MAKER)
      || is_word(req.addr, dvi_pkg::OFS_PRODUCT)
      || is_word(req.addr, dvi_pkg::OFS_MAKER_EXTRA)
      || is_word(req.addr, dvi_pkg::OFS_HW_REV)
      || is_word(req.addr, dvi_pkg::OFS_FW_REV)
      || is_word(req.addr, dvi_pkg::OFS_SERIAL)
      || is_word(req.addr, dvi_pkg::OFS_GEOMETRY)
      || is_word(req.addr, dvi_pkg::OFS_COLS)
      || is_word(req.addr, dvi_pkg::OFS_ROWS)
      || is_word(req.addr, dvi_pkg::OFS_ROI_COL)
      || is_word(req.addr, dvi_pkg::OFS_ROI_ROW);
   assign pick_legal = req.wdata <= 32'(dvi_pkg::DVI_SLOT5);
   assign mapped = hit_label || hit_pick || hit_data || hit_slot || hit_ro;

   // Label words store whatever software writes
   always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         for (int k = 0; k < dvi_pkg::LABEL_WORDS; k++) begin
            label_reg[k] <= dvi_pkg::LABEL_RST;
         end
      end else if (wr_commit && hit_label) begin
         label_reg[label_of_addr(req.addr)] <= req.wdata; // [RULE2]
      end
   end

   // Slot picker takes only codes of existing slots
   always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         pick_reg <= dvi_pkg::DVI_SLOT1;
      end else if (wr_commit && hit_pick && pick_legal) begin
         pick_reg <= dvi_pkg::dvi_slot_e'(req.wdata[2:0]); // [RULE9]
      end
   end

   // Direct slot writes and picked slot writes share one port
   assign slot_wr.en = wr_commit && (hit_slot || hit_data); // [RULE7]
   assign slot_wr.idx = hit_slot ? slot_of_addr(req.addr) : pick_reg; // [RULE9] [RULE10]
   assign slot_wr.data = req.wdata;

   // Scratch storage has no output other than readback
   dvi_scratch_bank #(
      .SLOTS(dvi_pkg::SLOTS)
   ) u_scratch (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_sync_reg),
      .i_wr(slot_wr),
      .o_slots(slots)
   ); // [RULE8]

   // ======================================================
   // Read data selection
   logic [31:0] rd_word;

   always_comb begin
      rd_word = dvi_pkg::READ_ZERO;
      if (hit_label) begin
         rd_word = label_reg[label_of_addr(req.addr)];
      end else if (hit_slot) begin
         rd_word = slots[slot_of_addr(req.addr)]; // [RULE10]
      end else if (hit_data) begin
         rd_word = slots[pick_reg]; // [RULE9]
      end else if (hit_pick) begin
         rd_word = {29'h0000_0000, pick_reg};
      end else begin
         unique case (req.addr[7:2])
            dvi_pkg::OFS_MAKER[7:2]: rd_word = MAKER_WORD; // [RULE1]
            dvi_pkg::OFS_PRODUCT[7:2]: rd_word = PRODUCT_WORD; // [RULE1]
            dvi_pkg::OFS_MAKER_EXTRA[7:2]: rd_word = EXTRA_WORD; // [RULE1]
            dvi_pkg::OFS_HW_REV[7:2]: rd_word = HW_REV_WORD; // [RULE1]
            dvi_pkg::OFS_FW_REV[7:2]: rd_word = FW_REV_WORD; // [RULE1]
            dvi_pkg::OFS_SERIAL[7:2]: rd_word = SERIAL_WORD; // [RULE6]
            dvi_pkg::OFS_GEOMETRY[7:2]: rd_word = dvi_pkg::GEOM_AREA; // [RULE3]
            dvi_pkg::OFS_COLS[7:2]: rd_word = IMAGER_COLS; // [RULE4]
            dvi_pkg::OFS_ROWS[7:2]: rd_word = IMAGER_ROWS; // [RULE4]
            dvi_pkg::OFS_ROI_COL[7:2]: rd_word = ROI_COL_LIMIT; // [RULE5]
            dvi_pkg::OFS_ROI_ROW[7:2]: rd_word = ROI_ROW_LIMIT; // [RULE5]
            default: rd_word = dvi_pkg::READ_ZERO;
         endcase
      end
   end

   // ======================================================
   // APB answer registers
   logic err_next;

   // Unmapped words and illegal picker codes answer with an error
   assign err_next = !mapped || (req.write && hit_pick && !pick_legal);

   // Read-only words ignore writes: no store and no error
   always_ff @(posedge i_sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= dvi_pkg::READ_ZERO;
      end else begin
         o_pready <= access;
         o_pslverr <= access && err_next; // [RULE11]
         o_prdata <= (access && !req.write) ? rd_word : dvi_pkg::READ_ZERO;
      end
   end

   // ======================================================
   // Checks
   logic rd_commit;
   assign rd_commit = commit && !req.write;

   property p_ro_info;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_FW_REV) |-> o_prdata == FW_REV_WORD;
   endproperty
   a_ro_info: assert property (p_ro_info) // [RULE1]
      else $error("firmware revision word read back wrong");

   property p_label_rw;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      wr_commit && is_word(req.addr, dvi_pkg::OFS_LABEL)
      |=> label_reg[0] == $past(req.wdata);
   endproperty
   a_label_rw: assert property (p_label_rw) // [RULE2]
      else $error("label word did not take the written value");

   property p_geometry;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_GEOMETRY)
      |-> o_prdata == dvi_pkg::GEOM_AREA && !o_pslverr;
   endproperty
   a_geometry: assert property (p_geometry) // [RULE3]
      else $error("geometry word is not area scan");

   property p_imager_size;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_ROWS) |-> o_prdata == IMAGER_ROWS;
   endproperty
   a_imager_size: assert property (p_imager_size) // [RULE4]
      else $error("imager rows read back wrong");

   property p_roi_limit;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_ROI_COL) |-> o_prdata == ROI_COL_LIMIT;
   endproperty
   a_roi_limit: assert property (p_roi_limit) // [RULE5]
      else $error("ROI column limit read back wrong");

   property p_serial;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_SERIAL) |-> o_prdata == SERIAL_WORD;
   endproperty
   a_serial: assert property (p_serial) // [RULE6]
      else $error("serial word read back wrong");

   property p_slot_store;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      wr_commit && is_word(req.addr, dvi_pkg::OFS_SLOT5)
      |=> slots[4] == $signed($past(req.wdata));
   endproperty
   a_slot_store: assert property (p_slot_store) // [RULE7]
      else $error("scratch value 5 did not take the written value");

   property p_slot_quiet;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      !wr_commit |=> $stable(slots[0]) && $stable(slots[2]);
   endproperty
   a_slot_quiet: assert property (p_slot_quiet) // [RULE8]
      else $error("scratch value changed without a write");

   property p_pick_route;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      wr_commit && hit_data && pick_reg == dvi_pkg::DVI_SLOT2
      |=> slots[1] == $signed($past(req.wdata));
   endproperty
   a_pick_route: assert property (p_pick_route) // [RULE9]
      else $error("picked slot write went astray");

   property p_direct_read;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_SLOT1) |-> o_prdata == slots[0];
   endproperty
   a_direct_read: assert property (p_direct_read) // [RULE10]
      else $error("direct scratch read returned another value");

   property p_ro_write;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      wr_commit && hit_ro |-> !o_pslverr ##1 $stable(pick_reg) && $stable(label_reg[0]);
   endproperty
   a_ro_write: assert property (p_ro_write) // [RULE11]
      else $error("read-only write had a side effect");

   property p_pick_refuse;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      wr_commit && hit_pick && !pick_legal |-> o_pslverr ##1 $stable(pick_reg);
   endproperty
   a_pick_refuse: assert property (p_pick_refuse) // [RULE9]
      else $error("picker took a code of no existing slot");

   property p_imager_cols;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_COLS) |-> o_prdata == IMAGER_COLS;
   endproperty
   a_imager_cols: assert property (p_imager_cols) // [RULE4]
      else $error("imager columns read back wrong");

   property p_roi_row;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && is_word(req.addr, dvi_pkg::OFS_ROI_ROW) |-> o_prdata == ROI_ROW_LIMIT;
   endproperty
   a_roi_row: assert property (p_roi_row) // [RULE5]
      else $error("ROI row limit read back wrong");

   property p_data_read;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      rd_commit && hit_data && pick_reg == dvi_pkg::DVI_SLOT3 |-> o_prdata == slots[2];
   endproperty
   a_data_read: assert property (p_data_read) // [RULE9]
      else $error("shared scratch read did not follow the picker");

   property p_answer_time;
      @(posedge i_sys_clk) disable iff (!rst_sync_reg)
      access |=> o_pready ##1 !o_pready;
   endproperty
   a_answer_time: assert property (p_answer_time) // Every access answers in the second access cycle
      else $error("APB answer not one cycle long after one wait");

endmodule // dvi_info_bank

// File: rtl/dvi_pkg.sv
// Purpose: Shared constants and types of the device information bank
// Assumes: APB word access, 8-bit byte address, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package dvi_pkg;

   // ======================================================
   // Sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SLOTS = 5;
   localparam int LABEL_WORDS = 4;

   // ======================================================
   // Register offsets
   localparam logic [7:0] OFS_MAKER = 8'h00;
   localparam logic [7:0] OFS_PRODUCT = 8'h04;
   localparam logic [7:0] OFS_MAKER_EXTRA = 8'h08;
   localparam logic [7:0] OFS_HW_REV = 8'h0c;
   localparam logic [7:0] OFS_FW_REV = 8'h10;
   localparam logic [7:0] OFS_SERIAL = 8'h14;
   localparam logic [7:0] OFS_LABEL = 8'h18;
   localparam logic [7:0] OFS_LABEL_LAST = 8'h24;
   localparam logic [7:0] OFS_GEOMETRY = 8'h28;
   localparam logic [7:0] OFS_COLS = 8'h2c;
   localparam logic [7:0] OFS_ROWS = 8'h30;
   localparam logic [7:0] OFS_ROI_COL = 8'h34;
   localparam logic [7:0] OFS_ROI_ROW = 8'h38;
   localparam logic [7:0] OFS_PICK = 8'h3c;
   localparam logic [7:0] OFS_SLOT_DATA = 8'h40;
   localparam logic [7:0] OFS_SLOT1 = 8'h44;
   localparam logic [7:0] OFS_SLOT5 = 8'h54;

   // ======================================================
   // Values after reset and fixed codes
   localparam logic [31:0] LABEL_RST = 32'h0000_0000;
   localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
   localparam logic [31:0] GEOM_LINE = 32'h0000_0000;
   localparam logic [31:0] GEOM_AREA = 32'h0000_0001;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // Slot selector codes
   typedef enum logic [2:0] {
      DVI_SLOT1 = 3'b000,
      DVI_SLOT2 = 3'b001,
      DVI_SLOT3 = 3'b010,
      DVI_SLOT4 = 3'b011,
      DVI_SLOT5 = 3'b100
   } dvi_slot_e;

   // Write request into the scratch bank
   typedef struct packed {
      logic en;
      logic [2:0] idx;
      logic signed [31:0] data;
   } dvi_slot_wr_s;

   // Held APB request fields
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } dvi_apb_req_s;

endpackage

// File: rtl/dvi_scratch_bank.sv
// Purpose: Five signed 32-bit scratch words with one write port
// Assumes: At most one write per clock
// Notes:   Contents drive nothing but software readback
`timescale 1ns/1ps
module dvi_scratch_bank #(
   parameter int SLOTS = dvi_pkg::SLOTS
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire dvi_pkg::dvi_slot_wr_s i_wr,
   output logic signed [31:0] o_slots [SLOTS]
);

   // ======================================================
   // Storage
   logic signed [31:0] slot_reg [SLOTS];

   if (SLOTS < 1 || SLOTS > 8) begin : g_chk
      $error("dvi_scratch_bank: SLOTS must be 1 to 8");
   end

   // Write the addressed word, hold the others
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < SLOTS; k++) begin
            slot_reg[k] <= dvi_pkg::SCRATCH_RST;
         end
      end else if (i_wr.en && (32'(i_wr.idx) < SLOTS)) begin
         slot_reg[i_wr.idx] <= i_wr.data;
      end
   end

   assign o_slots = slot_reg;

endmodule // dvi_scratch_bank

// File: tb/dvi_info_bank_tb.sv
// Purpose: Self-checking bench of the device information register bank
// Assumes: APB answer comes with one wait state; the bench still waits for pready
// Notes:   Identity words are set by the bench; their values are arbitrary
`timescale 1ns/1ps
module dvi_info_bank_tb;
   // ======================================================
   // Identity and size words handed to the bank
   localparam logic [31:0] P_MAKER = 32'h1a2b_0001;   // Arbitrary value
   localparam logic [31:0] P_PRODUCT = 32'h1a2b_0002; // Arbitrary value
   localparam logic [31:0] P_EXTRA = 32'h1a2b_0003;   // Arbitrary value
   localparam logic [31:0] P_HW = 32'h1a2b_0004;      // Arbitrary value
   localparam logic [31:0] P_FW = 32'h1a2b_0005;      // Arbitrary value
   localparam logic [31:0] P_SERIAL = 32'h1a2b_0006;  // Arbitrary value
   localparam logic [31:0] P_COLS = 32'h0000_0a00;
   localparam logic [31:0] P_ROWS = 32'h0000_0780;
   localparam logic [31:0] P_RCOL = 32'h0000_09f0;
   localparam logic [31:0] P_RROW = 32'h0000_0770;

   // ======================================================
   // Ports, counters and the table of ordinary cases
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } dvi_row_s;
   logic i_sys_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [31:0] rd;
   logic er;
   logic [31:0] slot_exp [5] = '{32'h8000_0000, 32'h7fff_ffff, 32'h0000_abcd,
                                 32'h0000_0001, 32'h1234_5678};
   // Read-only rows come first; later tests reuse them
   dvi_row_s rows [$] = '{
      '{1'b0, 8'h00, 32'h0, P_MAKER, 1'b0}, '{1'b0, 8'h04, 32'h0, P_PRODUCT, 1'b0},
      '{1'b0, 8'h08, 32'h0, P_EXTRA, 1'b0}, '{1'b0, 8'h0c, 32'h0, P_HW, 1'b0},
      '{1'b0, 8'h10, 32'h0, P_FW, 1'b0}, '{1'b0, 8'h14, 32'h0, P_SERIAL, 1'b0},
      '{1'b0, 8'h28, 32'h0, dvi_pkg::GEOM_AREA, 1'b0}, '{1'b0, 8'h2c, 32'h0, P_COLS, 1'b0},
      '{1'b0, 8'h30, 32'h0, P_ROWS, 1'b0}, '{1'b0, 8'h34, 32'h0, P_RCOL, 1'b0},
      '{1'b0, 8'h38, 32'h0, P_RROW, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h44, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h3c, 32'h0, 32'h0, 1'b0},
      '{1'b1, 8'h18, 32'h6c61_6231, 32'h0, 1'b0}, '{1'b1, 8'h1c, 32'h6c61_6232, 32'h0, 1'b0},
      '{1'b1, 8'h20, 32'h6c61_6233, 32'h0, 1'b0}, '{1'b1, 8'h24, 32'h6c61_6234, 32'h0, 1'b0},
      '{1'b0, 8'h18, 32'h0, 32'h6c61_6231, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h6c61_6232, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'h6c61_6233, 1'b0}, '{1'b0, 8'h24, 32'h0, 32'h6c61_6234, 1'b0},
      '{1'b1, 8'h44, 32'h8000_0000, 32'h0, 1'b0}, '{1'b1, 8'h48, 32'h7fff_ffff, 32'h0, 1'b0},
      '{1'b1, 8'h4c, 32'hffff_ffff, 32'h0, 1'b0}, '{1'b1, 8'h50, 32'h0000_0001, 32'h0, 1'b0},
      '{1'b1, 8'h54, 32'h1234_5678, 32'h0, 1'b0}, '{1'b0, 8'h44, 32'h0, 32'h8000_0000, 1'b0},
      '{1'b0, 8'h48, 32'h0, 32'h7fff_ffff, 1'b0}, '{1'b0, 8'h4c, 32'h0, 32'hffff_ffff, 1'b0},
      '{1'b0, 8'h50, 32'h0, 32'h0000_0001, 1'b0}, '{1'b0, 8'h54, 32'h0, 32'h1234_5678, 1'b0},
      '{1'b1, 8'h3c, 32'h2, 32'h0, 1'b0}, '{1'b0, 8'h40, 32'h0, 32'hffff_ffff, 1'b0},
      '{1'b1, 8'h40, 32'h0000_abcd, 32'h0, 1'b0}, '{1'b0, 8'h4c, 32'h0, 32'h0000_abcd, 1'b0},
      '{1'b0, 8'h48, 32'h0, 32'h7fff_ffff, 1'b0}, '{1'b1, 8'h3c, 32'h4, 32'h0, 1'b0},
      '{1'b1, 8'h3c, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'h3c, 32'h0, 32'h4, 1'b0},
      '{1'b0, 8'h58, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h58, 32'h55aa_55aa, 32'h0, 1'b1},
      '{1'b0, 8'hfc, 32'h0, 32'h0, 1'b1}, '{1'b0, 8'h54, 32'h0, 32'h1234_5678, 1'b0}};

   // ======================================================
   // Device under test
   dvi_info_bank #(
      .MAKER_WORD(P_MAKER),
      .PRODUCT_WORD(P_PRODUCT),
      .EXTRA_WORD(P_EXTRA),
      .HW_REV_WORD(P_HW),
      .FW_REV_WORD(P_FW),
      .SERIAL_WORD(P_SERIAL),
      .IMAGER_COLS(P_COLS),
      .IMAGER_ROWS(P_ROWS),
      .ROI_COL_LIMIT(P_RCOL),
      .ROI_ROW_LIMIT(P_RROW)
   ) dut (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr)
   );

   // ======================================================
   // Clock of 40 ns
   initial begin
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   // ======================================================
   // Verdict and comparison helpers
   task automatic report_and_stop();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= addr;
      i_pwdata <= wd;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      // Outputs read right at the edge still hold what the design showed before it
      do begin
         @(posedge i_sys_clk);
      end while (o_pready !== 1'b1);
      rdat = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   // ======================================================
   // Watchdog against a hung handshake
   initial begin
      #(40 * 6000);
      error_cnt++;
      report_and_stop();
   end

   // ======================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      // Table of ordinary cases
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
         check({31'h0, er}, {31'h0, rows[i].e});
         if (!rows[i].w) check(rd, rows[i].q);
      end
      // Writes to read-only words are dropped silently, also after scratch traffic
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, rows[i].a, ~rows[i].q, rd, er);
         check({31'h0, er}, 32'h0);
         apb(1'b0, rows[i].a, 32'h0, rd, er);
         check(rd, rows[i].q);
      end
      // Every picker code, reading and writing through the shared word
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, 8'h3c, 32'(k), rd, er);
         check({31'h0, er}, 32'h0);
         apb(1'b0, 8'h40, 32'h0, rd, er);
         check(rd, slot_exp[k]);
         apb(1'b1, 8'h40, 32'hc0de_0000 + 32'(k), rd, er);
         apb(1'b0, 8'(8'h44 + 4 * k), 32'h0, rd, er);
         check(rd, 32'hc0de_0000 + 32'(k));
      end
      // Reset in mid-run clears writable words and the picker
      @(posedge i_sys_clk);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      #1;
      check(o_prdata, dvi_pkg::READ_ZERO);
      check({30'h0, o_pready, o_pslverr}, 32'h0);
      @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      apb(1'b0, 8'h18, 32'h0, rd, er);
      check(rd, dvi_pkg::LABEL_RST);
      apb(1'b0, 8'h54, 32'h0, rd, er);
      check(rd, dvi_pkg::SCRATCH_RST);
      apb(1'b0, 8'h3c, 32'h0, rd, er);
      check(rd, 32'h0);
      report_and_stop();
   end
endmodule // dvi_info_bank_tb
